// ===== hw/zone_accumulate_release_ctrl.sv
// two-zone accumulate and release controller with wishbone registers
`timescale 1ns/100ps
`include "zone_consts.svh"
module zone_accumulate_release_ctrl import zone_pkg::*; #(
	parameter int TRK_W = `ZN_TRK_W,
	parameter int CNT_W = `ZN_CNT_W
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sensorUp,
	input wire logic sensorDn,
	input wire logic downClearIn,
	input wire logic confirmIn,
	input wire logic [TRK_W-1:0] trkIn1,
	input wire logic [TRK_W-1:0] trkIn2,
	output logic motorRunUp,
	output logic motorRunDn,
	output logic confirmOut,
	output logic irq
);
	localparam int NZ = `ZN_ZONES;
	localparam int SW = 4 + 2 * TRK_W;

	// pin synchroniser, three stages
	logic [SW-1:0] sync1_q, sync2_q, sync3_q, pinFilt_q;
	wire [SW-1:0] pinRaw = {trkIn2, trkIn1, confirmIn, downClearIn, sensorDn, sensorUp};
	// a bit moves only once stages two and three agree
	wire [SW-1:0] pinAgree = ~(sync2_q ^ sync3_q);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			pinFilt_q <= '0;
		end else begin
			sync1_q <= pinRaw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pinFilt_q <= (sync2_q & pinAgree) | (pinFilt_q & ~pinAgree);
		end
	end
	wire sensUpS = pinFilt_q[0];
	wire sensDnS = pinFilt_q[1];
	wire downClearS = pinFilt_q[2];
	wire confirmS = pinFilt_q[3];
	wire [TRK_W-1:0] trkIn1S = pinFilt_q[4 +: TRK_W];
	wire [TRK_W-1:0] trkIn2S = pinFilt_q[4 + TRK_W +: TRK_W];

	// software state
	logic [NZ-1:0] accum_q;
	logic [TRK_W-1:0] set1_q [NZ];
	logic [TRK_W-1:0] set2_q [NZ];
	logic [2:0] cfg_q;
	logic [`ZN_EV_W-1:0] istat_q, imask_q;
	logic ack_q, irq_q, confirm_q, runDn_q;
	logic [31:0] rdat_q;

	// lane results
	logic [CNT_W-1:0] arrCnt [NZ];
	logic [CNT_W-1:0] depCnt [NZ];
	logic [CNT_W-1:0] relCnt [NZ];
	logic [TRK_W-1:0] cur1 [NZ];
	logic [TRK_W-1:0] cur2 [NZ];
	logic [NZ-1:0] laneRun, laneHeld, evArr, evDep, evRel;

	// bus decode
	wire busReq = wb_cyc_i & wb_stb_i & ~ack_q;
	// a write lands on the edge at which the master sees ack, never earlier
	wire busWr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	wire inZone = (wb_adr_i[31:6] == 26'h0);
	wire zoneSel = wb_adr_i[5];
	wire [2:0] regIdx = wb_adr_i[4:2];
	wire isCfg = (wb_adr_i == `ZN_ADR_CFG);
	wire isIstat = (wb_adr_i == `ZN_ADR_ISTAT);
	wire isImask = (wb_adr_i == `ZN_ADR_IMASK);
	wire lowLanes = wb_sel_i[0] & wb_sel_i[1];

	// decoded write strobe for one zone register
	function automatic logic zoneWr(input logic wr, input logic zoneIn, input logic sel, input logic [2:0] idx,
			input logic [2:0] want, input logic z);
		zoneWr = wr & zoneIn & (sel == z) & (idx == want);
	endfunction

	// mode configuration
	wire singleZone = cfg_q[`ZN_CFG_SINGLE];
	wire trainMode = cfg_q[`ZN_CFG_TRAIN];
	wire jamEnable = cfg_q[`ZN_CFG_JAMEN];
	// confirm waiting only in one-carton mode with jam detect
	wire waitEn = ~trainMode & jamEnable;

	// zone wiring: upstream zone feeds the downstream zone
	// single zone ignores the second sensor
	wire [NZ-1:0] laneSensor = {sensDnS & ~singleZone, sensUpS};
	wire [NZ-1:0] laneDown = {downClearS, singleZone ? downClearS : laneRun[1]};
	wire [NZ-1:0] laneCfm = {confirmS, singleZone ? confirmS : evArr[1]};
	wire [TRK_W-1:0] laneIn1 [NZ];
	wire [TRK_W-1:0] laneIn2 [NZ];
	assign laneIn1[0] = trkIn1S;
	assign laneIn2[0] = trkIn2S;
	assign laneIn1[1] = cur1[0];
	assign laneIn2[1] = cur2[0];

	genvar z;
	generate
		for (z = 0; z < NZ; z++) begin : g_lane
			wire relWr = zoneWr(busWr, inZone, zoneSel, regIdx, `ZN_OFS_REL, 1'(z)) & lowLanes;
			wire setWr = (zoneWr(busWr, inZone, zoneSel, regIdx, `ZN_OFS_SET1, 1'(z))
				| zoneWr(busWr, inZone, zoneSel, regIdx, `ZN_OFS_SET2, 1'(z))) & lowLanes;
			zone_lane #(
				.TRK_W(TRK_W),
				.CNT_W(CNT_W)
			) u_lane (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.sensor(laneSensor[z]),
				.downClear(laneDown[z]),
				.confirmIn(laneCfm[z]),
				.waitEn(waitEn),
				.accumOn(accum_q[z]),
				.relWrite(relWr),
				.relValue(wb_dat_i[CNT_W-1:0]),
				.setTrkWrite(setWr),
				.setTrk1(set1_q[z]),
				.setTrk2(set2_q[z]),
				.inTrk1(laneIn1[z]),
				.inTrk2(laneIn2[z]),
				.arrCnt(arrCnt[z]),
				.depCnt(depCnt[z]),
				.relCnt(relCnt[z]),
				.curTrk1(cur1[z]),
				.curTrk2(cur2[z]),
				.run(laneRun[z]),
				.held(laneHeld[z]),
				.evArrive(evArr[z]),
				.evDepart(evDep[z]),
				.evRelease(evRel[z])
			);

			// accumulation bit and set-tracking words
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					accum_q[z] <= 1'b0;
					set1_q[z] <= '0;
					set2_q[z] <= '0;
				end else begin
					if (zoneWr(busWr, inZone, zoneSel, regIdx, `ZN_OFS_ACC, 1'(z)) && wb_sel_i[0])
						accum_q[z] <= wb_dat_i[`ZN_ACC_BIT];
					if (zoneWr(busWr, inZone, zoneSel, regIdx, `ZN_OFS_SET1, 1'(z)) && lowLanes)
						set1_q[z] <= wb_dat_i[TRK_W-1:0];
					if (zoneWr(busWr, inZone, zoneSel, regIdx, `ZN_OFS_SET2, 1'(z)) && lowLanes)
						set2_q[z] <= wb_dat_i[TRK_W-1:0];
				end
			end
		end
	endgenerate

	// events of both zones, upstream zone in the low half
	wire [`ZN_EV_W-1:0] evAll = {evRel[1], evDep[1], evArr[1], evRel[0], evDep[0], evArr[0]};
	wire [`ZN_EV_W-1:0] istatClr = (busWr && isIstat && wb_sel_i[0]) ? wb_dat_i[`ZN_EV_W-1:0] : '0;
	// an event in the clearing cycle survives the clear
	wire [`ZN_EV_W-1:0] istat_d = (istat_q & ~istatClr) | evAll;

	// configuration and interrupt registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_q <= `ZN_CFG_RESET;
			istat_q <= '0;
			imask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			if (busWr && isCfg && wb_sel_i[0]) cfg_q <= wb_dat_i[2:0];
			if (busWr && isImask && wb_sel_i[0]) imask_q <= wb_dat_i[`ZN_EV_W-1:0];
			istat_q <= istat_d;
			irq_q <= |(istat_d & imask_q);
		end
	end

	// read selection, zone words sit in the low bits
	wire [CNT_W-1:0] rdCnt = (regIdx == `ZN_OFS_ARR) ? arrCnt[zoneSel]
		: (regIdx == `ZN_OFS_DEP) ? depCnt[zoneSel] : relCnt[zoneSel];
	wire [TRK_W-1:0] rdTrk = (regIdx == `ZN_OFS_CUR1) ? cur1[zoneSel]
		: (regIdx == `ZN_OFS_CUR2) ? cur2[zoneSel]
		: (regIdx == `ZN_OFS_SET1) ? set1_q[zoneSel] : set2_q[zoneSel];
	wire idxIsCnt = (regIdx == `ZN_OFS_ARR) | (regIdx == `ZN_OFS_DEP) | (regIdx == `ZN_OFS_REL);
	wire [31:0] rdZone = (regIdx == `ZN_OFS_ACC) ? {30'h0, laneHeld[zoneSel], accum_q[zoneSel]}
		: idxIsCnt ? 32'(rdCnt) : 32'(rdTrk);
	// unmapped addresses answer with zero
	wire [31:0] rdMux = inZone ? rdZone
		: isCfg ? {29'h0, cfg_q}
		: isIstat ? 32'(istat_q)
		: isImask ? 32'(imask_q) : 32'h0000_0000;

	// one-cycle answer to every request
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			ack_q <= busReq;
			rdat_q <= busReq ? rdMux : 32'h0000_0000;
		end
	end

	// tell the module upstream that a carton landed here
	always_ff @(posedge core_clk) begin
		if (sys_rst) confirm_q <= 1'b0;
		else confirm_q <= evArr[0];
	end

	// second motor from its own flop; single-zone mode keeps it off
	always_ff @(posedge core_clk) begin
		if (sys_rst) runDn_q <= 1'b0;
		else runDn_q <= laneRun[1] & ~singleZone;
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign irq = irq_q;
	assign confirmOut = confirm_q;
	assign motorRunUp = laneRun[0];
	assign motorRunDn = runDn_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
	property p_ack_time;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
	endproperty
	a_ack_time: assert property (p_ack_time) else $error("ack not one cycle after request");
	property p_irq_level;
		(istat_q & imask_q) != '0 |-> irq_q || $past(istatClr) != '0 || $past(imask_q) != imask_q;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq low with unmasked status");
	property p_wait_mode;
		trainMode |-> !waitEn;
	endproperty
	a_wait_mode: assert property (p_wait_mode) else $error("confirm wait in train mode");
	property p_single;
		singleZone |=> !motorRunDn;
	endproperty
	a_single: assert property (p_single) else $error("second zone active in single mode");
	property p_dn_track;
		(evArr[1] && !singleZone) |-> cur1[1] == $past(cur1[0]);
	endproperty
	a_dn_track: assert property (p_dn_track) else $error("downstream zone lost tracking");
	property p_confirm;
		evArr[0] |=> confirmOut;
	endproperty
	a_confirm: assert property (p_confirm) else $error("no arrival confirmation sent");
endmodule

// ===== hw/zone_consts.svh
// offsets, field positions, reset values and widths of the zone controller
`ifndef ZONE_CONSTS_SVH
`define ZONE_CONSTS_SVH
`define ZN_TRK_W 16
`define ZN_CNT_W 16
`define ZN_ZONES 2
`define ZN_ZONE_STRIDE 32'h0000_0020
`define ZN_OFS_ACC 3'h0
`define ZN_OFS_ARR 3'h1
`define ZN_OFS_DEP 3'h2
`define ZN_OFS_CUR1 3'h3
`define ZN_OFS_CUR2 3'h4
`define ZN_OFS_SET1 3'h5
`define ZN_OFS_SET2 3'h6
`define ZN_OFS_REL 3'h7
`define ZN_ADR_CFG 32'h0000_0040
`define ZN_ADR_ISTAT 32'h0000_0044
`define ZN_ADR_IMASK 32'h0000_0048
`define ZN_ACC_BIT 0
`define ZN_CFG_SINGLE 0
`define ZN_CFG_TRAIN 1
`define ZN_CFG_JAMEN 2
`define ZN_CFG_RESET 3'h4
`define ZN_EV_W 6
`define ZN_SYNC_W 36
`endif

// ===== hw/zone_pkg.sv
// types shared by the zone controller files
package zone_pkg;
	// gray path: empty -> passing -> held
	typedef enum logic [1:0] {
		ZS_EMPTY = 2'b00,
		ZS_PASS = 2'b01,
		ZS_HOLD = 2'b11
	} zone_state_t;
	typedef logic [15:0] word_t;
endpackage

// ===== hw/zone_lane.sv
// one conveyor zone: counters, tracking words, hold and release handshake
`timescale 1ns/100ps
`include "zone_consts.svh"
module zone_lane import zone_pkg::*; #(
	parameter int TRK_W = `ZN_TRK_W,
	parameter int CNT_W = `ZN_CNT_W
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sensor,
	input wire logic downClear,
	input wire logic confirmIn,
	input wire logic waitEn,
	input wire logic accumOn,
	input wire logic relWrite,
	input wire logic [CNT_W-1:0] relValue,
	input wire logic setTrkWrite,
	input wire logic [TRK_W-1:0] setTrk1,
	input wire logic [TRK_W-1:0] setTrk2,
	input wire logic [TRK_W-1:0] inTrk1,
	input wire logic [TRK_W-1:0] inTrk2,
	output logic [CNT_W-1:0] arrCnt,
	output logic [CNT_W-1:0] depCnt,
	output logic [CNT_W-1:0] relCnt,
	output logic [TRK_W-1:0] curTrk1,
	output logic [TRK_W-1:0] curTrk2,
	output logic run,
	output logic held,
	output logic evArrive,
	output logic evDepart,
	output logic evRelease
);
	zone_state_t st_q, st_d;
	logic sensPrev_q, accPrev_q, relPend_q, trkPend_q, waitCfm_q;
	logic run_q, evArr_q, evDep_q, evRel_q;
	logic [CNT_W-1:0] arrCnt_q, depCnt_q, relCnt_q;
	logic [TRK_W-1:0] cur1_q, cur2_q;
	wire arrive = sensor & ~sensPrev_q;
	wire depart = ~sensor & sensPrev_q;
	wire accFall = accPrev_q & ~accumOn;
	// only the count plus one is new
	wire relNew = relWrite & (relValue == relCnt_q + CNT_W'(1));
	wire relGo = (st_q == ZS_HOLD) & relPend_q & downClear;
	wire holdWant = accumOn | waitCfm_q;

	// next zone state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ZS_EMPTY: begin
				if (arrive) st_d = holdWant ? ZS_HOLD : ZS_PASS;
			end
			ZS_PASS: begin
				if (depart) st_d = ZS_EMPTY;
			end
			ZS_HOLD: begin
				if (depart) st_d = ZS_EMPTY;
				else if (relGo || !holdWant) st_d = ZS_PASS;
			end
			default: st_d = ZS_EMPTY;
		endcase
	end

	// state, edges and motor
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= ZS_EMPTY;
			sensPrev_q <= 1'b0;
			accPrev_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sensPrev_q <= sensor;
			accPrev_q <= accumOn;
			run_q <= (st_d == ZS_EMPTY) | ((st_d == ZS_PASS) & downClear);
		end
	end

	// counts differ while occupied; departure catches up
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			arrCnt_q <= '0;
			depCnt_q <= '0;
		end else begin
			if (arrive) arrCnt_q <= arrCnt_q + CNT_W'(1);
			if (depart) depCnt_q <= arrCnt_q;
		end
	end

	// release disarms on use or on leaving accumulation; count advances
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			relPend_q <= 1'b0;
			relCnt_q <= '0;
		end else begin
			if (relNew) relPend_q <= 1'b1;
			else if (relGo || accFall) relPend_q <= 1'b0;
			if (relGo) relCnt_q <= relCnt_q + CNT_W'(1);
		end
	end

	// new carton data on arrival; set words only through release
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trkPend_q <= 1'b0;
			cur1_q <= '0;
			cur2_q <= '0;
		end else begin
			if (setTrkWrite) trkPend_q <= 1'b1;
			else if (relGo || accFall) trkPend_q <= 1'b0;
			if (arrive) begin
				cur1_q <= inTrk1;
				cur2_q <= inTrk2;
			end else if (relGo && trkPend_q) begin
				cur1_q <= setTrk1;
				cur2_q <= setTrk2;
			end
		end
	end

	// wait for the receiver after a departure; set beats clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) waitCfm_q <= 1'b0;
		else if (depart && waitEn) waitCfm_q <= 1'b1;
		else if (confirmIn || !waitEn) waitCfm_q <= 1'b0;
	end

	// event pulses for the status register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			evArr_q <= 1'b0;
			evDep_q <= 1'b0;
			evRel_q <= 1'b0;
		end else begin
			evArr_q <= arrive;
			evDep_q <= depart;
			evRel_q <= relGo;
		end
	end

	assign arrCnt = arrCnt_q;
	assign depCnt = depCnt_q;
	assign relCnt = relCnt_q;
	assign curTrk1 = cur1_q;
	assign curTrk2 = cur2_q;
	assign run = run_q;
	assign held = (st_q == ZS_HOLD);
	assign evArrive = evArr_q;
	assign evDepart = evDep_q;
	assign evRelease = evRel_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_dep_equal;
		depart |=> depCnt_q == arrCnt_q;
	endproperty
	a_dep_equal: assert property (p_dep_equal) else $error("departure count not caught up");
	property p_hold_acc;
		(st_q == ZS_EMPTY && arrive && accumOn) |=> st_q == ZS_HOLD && !run_q;
	endproperty
	a_hold_acc: assert property (p_hold_acc) else $error("carton not held");
	property p_rel_count;
		relGo |=> relCnt_q == $past(relCnt_q) + CNT_W'(1) && !relPend_q;
	endproperty
	a_rel_count: assert property (p_rel_count) else $error("release count not advanced");
	property p_cancel;
		(accFall && !waitCfm_q && st_q == ZS_HOLD && !depart) |=> st_q == ZS_PASS && !trkPend_q;
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel did not release");
	property p_wait_hold;
		(st_q == ZS_EMPTY && arrive && waitCfm_q) |=> st_q == ZS_HOLD;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("arrival not held for confirm");
endmodule

// ===== sim/conveyor_far_model.sv
// far-side conveyor model: moves cartons into the downstream zone, confirms hand-off
`timescale 1ns/100ps
module conveyor_far_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sensorUp,
	input wire logic motorRunUp,
	input wire logic motorRunDn,
	input wire logic stall,
	input wire logic [7:0] lag,
	output logic sensorDn,
	output logic downClearIn,
	output logic confirmIn
);
	logic [7:0] travel;
	logic [7:0] outCnt;
	logic [3:0] cfmCnt;
	logic upPrev;
	// a stalled receiver reports downstream as full
	assign downClearIn = !stall;
	// transit, clearing and confirmation; lag lets the bench pick prompt or slow answers
	always_ff @(posedge core_clk) begin
		upPrev <= sensorUp;
		if (sys_rst) begin
			travel <= 8'h0;
			outCnt <= 8'h0;
			cfmCnt <= 4'h0;
			sensorDn <= 1'h0;
			confirmIn <= 1'h0;
		end else begin
			if (upPrev && !sensorUp && motorRunUp) begin
				travel <= lag;
			end else if (travel > 8'h1) begin
				travel <= travel - 8'h1;
			end else if (travel == 8'h1) begin
				travel <= 8'h0;
				sensorDn <= 1'h1;
			end
			outCnt <= (sensorDn && motorRunDn) ? outCnt + 8'h1 : 8'h0;
			if (cfmCnt != 4'h0) begin
				cfmCnt <= cfmCnt - 4'h1;
			end
			if (outCnt == 8'hA) begin
				sensorDn <= 1'h0;
				cfmCnt <= 4'hA;
			end
			confirmIn <= (cfmCnt != 4'h0) && (cfmCnt < 4'h7);
		end
	end
endmodule

// ===== sim/zone_accumulate_release_ctrl_tb.sv
// self-checking bench of the two-zone accumulate and release controller
`timescale 1ns/100ps
`include "zone_consts.svh"
module zone_accumulate_release_ctrl_tb import zone_pkg::*;;
	logic core_clk, sys_rst, cyc, stb, we, ack, sensorUp, sensorDn, downClearIn, confirmIn;
	logic runUp, runDn, cfmOut, irq, stall;
	logic [7:0] lag;
	logic [31:0] adr, wdat, rdat, rv, rc;
	word_t t1, t2, s1, s2, trk1, trk2;
	int seed, errorCnt, nTests, i, cfmPulses;
	zone_accumulate_release_ctrl zone_accumulate_release_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sensorUp(sensorUp), .sensorDn(sensorDn),
		.downClearIn(downClearIn), .confirmIn(confirmIn), .trkIn1(trk1), .trkIn2(trk2),
		.motorRunUp(runUp), .motorRunDn(runDn), .confirmOut(cfmOut), .irq(irq));
	conveyor_far_model conveyor_far_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .sensorUp(sensorUp),
		.motorRunUp(runUp), .motorRunDn(runDn), .stall(stall), .lag(lag), .sensorDn(sensorDn),
		.downClearIn(downClearIn), .confirmIn(confirmIn));
	// free-running core clock
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	// confirmation pulses sent upstream, one per upstream arrival
	always @(posedge core_clk) begin
		if (cfmOut === 1'h1) cfmPulses <= cfmPulses + 1;
	end
	function automatic logic [31:0] za(input logic z, input logic [2:0] o);
		return {26'h0, z, o, 2'h0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			errorCnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (ack !== 1'h1 && k < 50);
		rv = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		chk("ack", 32'h1, {31'h0, ack});
	endtask
	task automatic rdChk(input string nm, input logic [31:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk(nm, e, rv);
	endtask
	// new carton with random tracking reaches the upstream sensor
	task automatic arrive();
		trk1 <= word_t'($random(seed));
		trk2 <= word_t'($random(seed));
		@(posedge core_clk);
		sensorUp <= 1'h1;
		t1 = trk1;
		t2 = trk2;
		repeat (8) @(posedge core_clk);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// hang guard, far beyond the expected one thousand or so cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		errorCnt++;
		$display("FAIL watchdog expected done seen hang");
		finish_test();
	end
	initial begin
		seed = 84117;
		{sys_rst, cyc, stb, we, sensorUp, stall, adr, wdat, trk1, trk2} = '0;
		sys_rst = 1'h1;
		lag = 8'h14;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'h0;
		rdChk("cfg", `ZN_ADR_CFG, 32'h4); // default mode
		rdChk("unmapped", 32'h80, 32'h0);
		rdChk("rel0", za(0, `ZN_OFS_REL), 32'h0); // count start
		wb(1'h1, `ZN_ADR_IMASK, 32'h3F);
		wb(1'h1, za(0, `ZN_OFS_ACC), 32'h1);
		$display("test registers done");
		// two cartons held, retagged and released in turn
		for (i = 0; i < 2; i++) begin
			lag <= 8'hA + 8'($unsigned($random(seed)) % 40);
			arrive();
			rdChk("held0", za(0, `ZN_OFS_ACC), 32'h3); // hold
			chk("runUp", 32'h0, {31'h0, runUp}); // hold
			rdChk("arr0", za(0, `ZN_OFS_ARR), i + 1); // counts
			rdChk("dep0", za(0, `ZN_OFS_DEP), i); // counts
			rdChk("cur1", za(0, `ZN_OFS_CUR1), {16'h0, t1}); // tracking
			rdChk("cur2", za(0, `ZN_OFS_CUR2), {16'h0, t2}); // tracking
			chk("irq", 32'h1, {31'h0, irq});
			wb(1'h1, `ZN_ADR_ISTAT, 32'h3F);
			repeat (2) @(posedge core_clk);
			chk("irqClr", 32'h0, {31'h0, irq});
			wb(1'h0, za(0, `ZN_OFS_REL), 32'h0);
			rc = rv;
			wb(1'h1, za(0, `ZN_OFS_REL), rc + 32'h2);
			rdChk("badRel", za(0, `ZN_OFS_ACC), 32'h3); // exact value
			s1 = word_t'($random(seed));
			s2 = word_t'($random(seed));
			wb(1'h1, za(0, `ZN_OFS_SET1), {16'h0, s1});
			wb(1'h1, za(0, `ZN_OFS_SET2), {16'h0, s2});
			wb(1'h1, za(0, `ZN_OFS_REL), rc + 32'h1);
			repeat (4) @(posedge core_clk);
			rdChk("relCnt", za(0, `ZN_OFS_REL), rc + 32'h1); // advance
			rdChk("released", za(0, `ZN_OFS_ACC), 32'h1); // release
			rdChk("set1", za(0, `ZN_OFS_CUR1), {16'h0, s1}); // retag
			rdChk("set2", za(0, `ZN_OFS_CUR2), {16'h0, s2}); // retag
			sensorUp <= 1'h0;
			repeat (8) @(posedge core_clk);
			rdChk("depEq", za(0, `ZN_OFS_DEP), i + 1); // departure
			repeat (100) @(posedge core_clk);
			rdChk("dnCur1", za(1, `ZN_OFS_CUR1), {16'h0, s1}); // copy
			rdChk("dnArr", za(1, `ZN_OFS_ARR), i + 1); // copy
		end
		$display("test release done");
		// downstream zone holds while the far side is full
		wb(1'h1, `ZN_ADR_IMASK, 32'h0);
		wb(1'h1, za(0, `ZN_OFS_ACC), 32'h0);
		wb(1'h1, za(1, `ZN_OFS_ACC), 32'h1);
		stall <= 1'h1;
		arrive();
		sensorUp <= 1'h0;
		repeat (100) @(posedge core_clk);
		rdChk("held1", za(1, `ZN_OFS_ACC), 32'h3); // hold
		chk("irqMask", 32'h0, {31'h0, irq});
		wb(1'h1, `ZN_ADR_IMASK, 32'h8);
		repeat (2) @(posedge core_clk);
		chk("irqDn", 32'h1, {31'h0, irq});
		wb(1'h1, `ZN_ADR_ISTAT, 32'h3F);
		wb(1'h0, za(1, `ZN_OFS_REL), 32'h0);
		rc = rv;
		wb(1'h1, za(1, `ZN_OFS_REL), rc + 32'h1);
		repeat (20) @(posedge core_clk);
		rdChk("pend", za(1, `ZN_OFS_ACC), 32'h3); // pending
		chk("runDn", 32'h0, {31'h0, runDn}); // pending
		stall <= 1'h0;
		repeat (6) @(posedge core_clk);
		rdChk("late", za(1, `ZN_OFS_ACC), 32'h1); // late release
		rdChk("rel1", za(1, `ZN_OFS_REL), rc + 32'h1); // advance
		repeat (60) @(posedge core_clk);
		wb(1'h1, za(1, `ZN_OFS_ACC), 32'h0);
		$display("test pending done");
		// cancel, then a new carton waits on the slow confirmation
		wb(1'h1, za(0, `ZN_OFS_ACC), 32'h1);
		lag <= 8'h3C;
		arrive();
		wb(1'h1, za(0, `ZN_OFS_SET1), 32'h1234);
		wb(1'h1, za(0, `ZN_OFS_ACC), 32'h0);
		repeat (4) @(posedge core_clk);
		rdChk("cancel", za(0, `ZN_OFS_ACC), 32'h0); // cancel
		chk("runCan", 32'h1, {31'h0, runUp}); // cancel
		rdChk("noSet", za(0, `ZN_OFS_CUR1), {16'h0, t1}); // discard
		sensorUp <= 1'h0;
		repeat (3) @(posedge core_clk);
		arrive();
		rdChk("waitCfm", za(0, `ZN_OFS_ACC), 32'h2); // hold
		repeat (80) @(posedge core_clk);
		rdChk("cfmDone", za(0, `ZN_OFS_ACC), 32'h0); // confirm
		sensorUp <= 1'h0;
		repeat (100) @(posedge core_clk);
		$display("test confirm done");
		// train mode drops the confirm wait, then single zone runs on the pins
		wb(1'h1, `ZN_ADR_CFG, 32'h6);
		arrive();
		sensorUp <= 1'h0;
		repeat (3) @(posedge core_clk);
		arrive();
		rdChk("train", za(0, `ZN_OFS_ACC), 32'h0); // no wait in train mode
		sensorUp <= 1'h0;
		repeat (100) @(posedge core_clk);
		wb(1'h1, `ZN_ADR_CFG, 32'h5);
		wb(1'h1, za(0, `ZN_OFS_ACC), 32'h1);
		stall <= 1'h1;
		repeat (2) @(posedge core_clk);
		chk("runDnSingle", 32'h0, {31'h0, runDn}); // second zone off
		arrive();
		wb(1'h0, za(0, `ZN_OFS_REL), 32'h0);
		rc = rv;
		wb(1'h1, za(0, `ZN_OFS_REL), rc + 32'h1);
		repeat (4) @(posedge core_clk);
		rdChk("single", za(0, `ZN_OFS_ACC), 32'h3); // pin full
		stall <= 1'h0;
		repeat (8) @(posedge core_clk);
		rdChk("singleGo", za(0, `ZN_OFS_ACC), 32'h1); // pin clear
		rdChk("relSingle", za(0, `ZN_OFS_REL), rc + 32'h1); // advance
		chk("cfmOut", 32'h8, cfmPulses); // one pulse per arrival
		$display("test modes done");
		finish_test();
	end
endmodule
